// [core/muc_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "muc_params.svh"

module muc_ctrl #(
  parameter int PEND_W = 4,
  parameter int CNT_W  = 11
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire muc_pkg::muc_acc_t  acc_in,
  output logic                  acc_ack_out,
  output logic                  acc_hit_out,
  output logic [63:0]           acc_rdata_out,
  input  wire logic             branch_issue_in,
  input  wire logic             branch_resolve_in,
  input  wire logic             cti_fetch_in,
  input  wire logic             fetch_valid_in,
  input  wire logic [5:0]       fetch_bytes_in,
  input  wire logic [63:0]      watch_addr_in,
  input  wire muc_pkg::muc_dacc_t dacc_in,
  input  wire logic             ifa_valid_in,
  input  wire logic [63:0]      ifa_va_in,
  input  wire logic [63:0]      ifa_xlate_pa_in,
  output logic                  bp_disable_out,
  output logic                  mem_hold_out,
  output logic                  hw_prefetch_off_out,
  output logic                  prefetch_squash_out,
  output logic                  fetch_stop_out,
  output logic                  phys_watch_exception_out,
  output logic                  virt_watch_exception_out,
  output logic [63:0]           data_pa_out,
  output logic [63:0]           instr_pa_out
);
  import muc_pkg::*;

  // =========================================================
  // Register access
  // =========================================================
  logic [63:0]       ctrl_reg, ctrl_next;
  logic              ack_reg, ack_next;
  logic              hit_reg, hit_next;
  logic [63:0]       rdata_reg, rdata_next;
  logic              acc_hit;
  logic              wr_hit;

  assign acc_hit = acc_in.valid && acc_in.space == `MUC_SPACE
                   && acc_in.va == `MUC_OFFSET;
  assign wr_hit  = acc_hit && acc_in.write;

  // Only implemented bits are ever stored, so dead bits read 0
  always_comb begin
    ctrl_next  = ctrl_reg;
    ack_next   = acc_in.valid;
    hit_next   = acc_hit;
    rdata_next = 64'h0;
    if (wr_hit) begin
      ctrl_next = acc_in.wdata & `MUC_WR_MASK;
    end
    if (acc_hit && !acc_in.write) begin
      rdata_next = ctrl_reg & `MUC_WR_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg  <= `MUC_RESET;
      ack_reg   <= 1'b0;
      hit_reg   <= 1'b0;
      rdata_reg <= 64'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      ack_reg   <= ack_next;
      hit_reg   <= hit_next;
      rdata_reg <= rdata_next;
    end
  end

  assign acc_ack_out   = ack_reg;
  assign acc_hit_out   = hit_reg;
  assign acc_rdata_out = rdata_reg;

  // =========================================================
  // Speculation limit
  // =========================================================
  logic              spec_next;
  logic [PEND_W-1:0] pend_reg, pend_next;
  logic [CNT_W:0]    fcnt_reg, fcnt_next;
  logic              bpd_reg, hold_reg, pfo_reg, stop_reg;
  logic              bpd_next, hold_next, pfo_next, stop_next;

  assign spec_next = ctrl_next[`MUC_SPEC_BIT];

  // Outputs follow the next register value so a write acts on
  // the very edge that takes it, with no extra cycle of lag
  always_comb begin
    // Branch count saturates at 15 instead of wrapping, so a burst of up
    // to 15 unresolved branches can never drop the hold early
    pend_next = pend_reg;
    if (branch_issue_in && !branch_resolve_in && pend_reg != '1) begin
      pend_next = pend_reg + PEND_W'(1);
    end else if (!branch_issue_in && branch_resolve_in
                 && pend_reg != '0) begin
      pend_next = pend_reg - PEND_W'(1);
    end
    // Count restarts at each transfer and stops adding once it reaches the cap
    fcnt_next = fcnt_reg;
    if (cti_fetch_in) begin
      fcnt_next = '0;
    end else if (fetch_valid_in
                 && fcnt_reg < (CNT_W+1)'(`MUC_FETCH_LIMIT)) begin
      fcnt_next = fcnt_reg + (CNT_W+1)'(fetch_bytes_in);
    end
    bpd_next  = spec_next;
    hold_next = spec_next && pend_next != '0;
    pfo_next  = spec_next;
    stop_next = spec_next
                && fcnt_next >= (CNT_W+1)'(`MUC_FETCH_LIMIT);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= '0;
      fcnt_reg <= '0;
      bpd_reg  <= 1'b0;
      hold_reg <= 1'b0;
      pfo_reg  <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      fcnt_reg <= fcnt_next;
      bpd_reg  <= bpd_next;
      hold_reg <= hold_next;
      pfo_reg  <= pfo_next;
      stop_reg <= stop_next;
    end
  end

  assign bp_disable_out      = bpd_reg;
  assign mem_hold_out        = hold_reg;
  assign hw_prefetch_off_out = pfo_reg;
  assign prefetch_squash_out = pfo_reg;
  assign fetch_stop_out      = stop_reg;

  // =========================================================
  // Watchpoints and translation bypass
  // =========================================================
  logic [7:0]  wmask;
  logic        vmatch, pmatch;
  logic        pexc_reg, pexc_next, vexc_reg, vexc_next;
  logic [63:0] dpa_reg, dpa_next, ipa_reg, ipa_next;

  assign wmask = ctrl_reg[`MUC_MASK_HI:`MUC_MASK_LO];

  // One mask serves both readings of the single watch address;
  // the physical compare drops high address bits
  always_comb begin
    vmatch = dacc_in.va[63:3] == watch_addr_in[63:3]
             && (dacc_in.bytes & wmask) != 8'h00;
    pmatch = dacc_in.xlate_pa[`MUC_PA_TOP:3]
             == watch_addr_in[`MUC_PA_TOP:3]
             && (dacc_in.bytes & wmask) != 8'h00;
    vexc_next = dacc_in.valid && vmatch
                && ((dacc_in.read && ctrl_reg[`MUC_VRD_BIT])
                || (dacc_in.write && ctrl_reg[`MUC_VWR_BIT]));
    // Virtual wins when both would fire
    pexc_next = dacc_in.valid && pmatch && !vexc_next
                && ((dacc_in.read && ctrl_reg[`MUC_PRD_BIT])
                || (dacc_in.write && ctrl_reg[`MUC_PWR_BIT]));
    dpa_next = dpa_reg;
    if (dacc_in.valid) begin
      dpa_next = ctrl_reg[`MUC_DXL_BIT] ? dacc_in.xlate_pa
                                        : dacc_in.va;
    end
    ipa_next = ipa_reg;
    if (ifa_valid_in) begin
      ipa_next = ctrl_reg[`MUC_IXL_BIT] ? ifa_xlate_pa_in
                                        : ifa_va_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pexc_reg <= 1'b0;
      vexc_reg <= 1'b0;
      dpa_reg  <= 64'h0;
      ipa_reg  <= 64'h0;
    end else begin
      pexc_reg <= pexc_next;
      vexc_reg <= vexc_next;
      dpa_reg  <= dpa_next;
      ipa_reg  <= ipa_next;
    end
  end

  assign phys_watch_exception_out = pexc_reg;
  assign virt_watch_exception_out = vexc_reg;
  assign data_pa_out              = dpa_reg;
  assign instr_pa_out             = ipa_reg;

  // =========================================================
  // Checks
  // =========================================================
  default clocking chk_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_legacy_zero: assert property (
    acc_ack_out |-> (acc_rdata_out & `MUC_LEGACY_MASK) == 64'h0)
    else $error("legacy bits read nonzero");

  chk_cache_zero: assert property (
    acc_ack_out |-> acc_rdata_out[1:0] == 2'b00)
    else $error("cache enable bits read nonzero");

  chk_rsvd_zero: assert property (
    acc_ack_out |-> (acc_rdata_out & `MUC_RSVD_MASK) == 64'h0)
    else $error("reserved bits read nonzero");

  chk_spec_bpd: assert property (
    wr_hit && acc_in.wdata[`MUC_SPEC_BIT] |=> bp_disable_out
    ##0 hw_prefetch_off_out)
    else $error("branch prediction not disabled");

  chk_hold_branch: assert property (
    ctrl_reg[`MUC_SPEC_BIT] && !wr_hit && branch_issue_in
    && !branch_resolve_in |=> mem_hold_out)
    else $error("memory op not held behind branch");

  chk_pf_off: assert property (
    wr_hit && !acc_in.wdata[`MUC_SPEC_BIT]
    |=> !prefetch_squash_out && !hw_prefetch_off_out)
    else $error("prefetch stays off after clear");

  chk_fetch_cap: assert property (
    ctrl_reg[`MUC_SPEC_BIT] && !acc_in.valid && !cti_fetch_in
    && fcnt_reg >= (CNT_W+1)'(`MUC_FETCH_LIMIT) |=> fetch_stop_out)
    else $error("fetch not stopped at cap");

  chk_pa_watch: assert property (
    dacc_in.valid && dacc_in.read && pmatch && ctrl_reg[`MUC_PRD_BIT]
    && !vexc_next |=> phys_watch_exception_out)
    else $error("physical watch missed");

  chk_va_watch: assert property (
    dacc_in.valid && dacc_in.write && vmatch && ctrl_reg[`MUC_VWR_BIT]
    |=> virt_watch_exception_out && !phys_watch_exception_out)
    else $error("virtual watch missed");

  chk_dxl_bypass: assert property (
    dacc_in.valid && !ctrl_reg[`MUC_DXL_BIT]
    |=> data_pa_out == $past(dacc_in.va))
    else $error("data address not passed through");

  chk_ixl_bypass: assert property (
    ifa_valid_in && !ctrl_reg[`MUC_IXL_BIT]
    |=> instr_pa_out == $past(ifa_va_in))
    else $error("instr address not passed through");

  chk_hold_idle: assert property (
    pend_reg == '0 && !branch_issue_in |=> !mem_hold_out)
    else $error("memory op held with no branch pending");

  chk_write_take: assert property (
    wr_hit |=> ctrl_reg == ($past(acc_in.wdata) & `MUC_WR_MASK))
    else $error("register write not taken as masked");

  chk_fetch_restart: assert property (
    cti_fetch_in |=> !fetch_stop_out)
    else $error("fetch stop survives a control transfer");

  chk_ixl_xlate: assert property (
    ifa_valid_in && ctrl_reg[`MUC_IXL_BIT]
    |=> instr_pa_out == $past(ifa_xlate_pa_in))
    else $error("instr address not translated");

  chk_watch_excl: assert property (
    !(phys_watch_exception_out && virt_watch_exception_out))
    else $error("both watch pulses raised together");

  chk_watch_idle: assert property (
    !dacc_in.valid |=> !phys_watch_exception_out
    && !virt_watch_exception_out)
    else $error("watch pulse without a data access");

  cov_spec_set: cover property (wr_hit ##1 bp_disable_out);
  cov_fetch_stop: cover property ($rose(fetch_stop_out));
  cov_both_watch: cover property (
    dacc_in.valid && vmatch && pmatch ##1 virt_watch_exception_out);
  cov_hold_release: cover property ($fell(mem_hold_out));
  cov_pa_watch: cover property ($rose(phys_watch_exception_out));
endmodule : muc_ctrl

`default_nettype wire

// [shared/muc_params.svh]
`ifndef MUC_PARAMS_SVH
`define MUC_PARAMS_SVH
// Address of the control register in alternate space
`define MUC_SPACE        8'h45
`define MUC_OFFSET       64'h0000_0000_0000_0000
// Field positions
`define MUC_SPEC_BIT     41
`define MUC_MASK_HI      32
`define MUC_MASK_LO      25
`define MUC_PRD_BIT      24
`define MUC_PWR_BIT      23
`define MUC_VRD_BIT      22
`define MUC_VWR_BIT      21
`define MUC_DXL_BIT      3
`define MUC_IXL_BIT      2
// Bits that hold state; all others read zero
`define MUC_WR_MASK      64'h0000_0201_ffe0_000c
`define MUC_LEGACY_MASK  64'h0003_fc00_0000_0000
`define MUC_CACHE_MASK   64'h0000_0000_0000_0003
`define MUC_RSVD_MASK    64'hfffc_01fe_001f_fff0
`define MUC_RESET        64'h0000_0000_0000_0000
// Instruction bytes allowed past a control transfer
`define MUC_FETCH_LIMIT  1024
// Physical compare ignores address bits above this one
`define MUC_PA_TOP       40
`endif

// [shared/muc_pkg.sv]
`default_nettype none
package muc_pkg;
  // Alternate-space register access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  space;
    logic [63:0] va;
    logic [63:0] wdata;
  } muc_acc_t;
  // One data access presented for translation and watch compare
  typedef struct packed {
    logic        valid;
    logic        read;
    logic        write;
    logic [7:0]  bytes;
    logic [63:0] va;
    logic [63:0] xlate_pa;
  } muc_dacc_t;
endpackage : muc_pkg
`default_nettype wire

// [test/muc_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "muc_params.svh"

module testbench;
  import muc_pkg::*;
  // Bits 41, 32:21, 3 and 2 hold state
  localparam logic [63:0] RW_BITS = 64'h0000_0201_ffe0_000c;
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  muc_acc_t         acc_in;
  muc_dacc_t        dacc_in;
  logic             br_is, br_rs, cti, fv, ifa_v;
  logic [5:0]       fb;
  logic [63:0]      watch, ifa_va, ifa_pa;
  logic             ack, hit, bp, hold, hwpf, sq, stop, pw, vw;
  logic [63:0]      rdata, dpa, ipa;
  logic [64:0]      exp_q[$];
  logic [64:0]      exp_w;
  logic [63:0]      reg_m = 64'h0;
  logic [15:0]      lf = 16'h94fa;
  int               failures = 0;
  int               check_count = 0;

  always #5 clk_in = ~clk_in;

  muc_ctrl muc_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .acc_in(acc_in),
    .acc_ack_out(ack), .acc_hit_out(hit), .acc_rdata_out(rdata),
    .branch_issue_in(br_is), .branch_resolve_in(br_rs), .cti_fetch_in(cti),
    .fetch_valid_in(fv), .fetch_bytes_in(fb), .watch_addr_in(watch),
    .dacc_in(dacc_in), .ifa_valid_in(ifa_v), .ifa_va_in(ifa_va),
    .ifa_xlate_pa_in(ifa_pa), .bp_disable_out(bp), .mem_hold_out(hold),
    .hw_prefetch_off_out(hwpf), .prefetch_squash_out(sq),
    .fetch_stop_out(stop), .phys_watch_exception_out(pw),
    .virt_watch_exception_out(vw), .data_pa_out(dpa), .instr_pa_out(ipa));

  // ==========================================================
  // Checking helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input string nm, input logic [64:0] e,
                       input logic [64:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task end_of_test;
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // Register access; the expected answer is queued for the monitor
  task automatic acc(input logic wr, input logic [7:0] sp,
                     input logic [63:0] va, input logic [63:0] wd);
    logic h;
    h = (sp == 8'h45) && (va == 64'h0);
    @(negedge clk_in);
    acc_in = '{valid: 1'b1, write: wr, space: sp, va: va, wdata: wd};
    exp_q.push_back({h, (h && !wr) ? reg_m : 64'h0});
    if (h && wr) reg_m = wd & RW_BITS;
    @(negedge clk_in);
    acc_in.valid = 1'b0;
  endtask : acc

  // One data access, answer a cycle later
  task automatic dacc(input logic rd, input logic wr, input logic [7:0] be,
                      input logic [63:0] va, input logic [63:0] pa,
                      input logic ev, input logic ep);
    @(negedge clk_in);
    dacc_in = '{valid: 1'b1, read: rd, write: wr, bytes: be, va: va,
                xlate_pa: pa};
    @(negedge clk_in);
    dacc_in.valid = 1'b0;
    check("watch pulses", {ev, ep}, {vw, pw});
    check("data address", reg_m[3] ? pa : va, dpa);
  endtask : dacc

  task automatic ifa(input logic [63:0] va, input logic [63:0] pa);
    @(negedge clk_in);
    {ifa_v, ifa_va, ifa_pa} = {1'b1, va, pa};
    @(negedge clk_in);
    ifa_v = 1'b0;
    check("instr address", reg_m[2] ? pa : va, ipa);
  endtask : ifa

  // Monitor takes the oldest queued answer on every acknowledge
  always @(negedge clk_in) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected ack", 65'h0, 65'h1);
      end else begin
        exp_w = exp_q.pop_front();
        check("answer", exp_w, {hit, rdata});
      end
    end
  end

  // Hang guard, far beyond the 77 or so cycles of the run
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [63:0] wd;
    wd = 64'h0;
    acc_in = '0;
    dacc_in = '0;
    {br_is, br_rs, cti, fv, ifa_v, fb} = '0;
    {ifa_va, ifa_pa} = '0;
    watch = 64'h0000_0123_4567_89a8;
    repeat (3) @(negedge clk_in);
    check("reset levels", 65'h0, {ack, hit, bp, hold, hwpf, sq});
    check("reset pulses", 65'h0, {stop, pw, vw, |dpa, |ipa});
    rst_in = 1'b0;
    acc(1'b0, 8'h45, 64'h0, 64'h0);
    acc(1'b1, 8'h45, 64'h0, '1);
    acc(1'b0, 8'h45, 64'h0, 64'h0);
    check("limit levels", 3'b111, {bp, hwpf, sq});
    // Wrong space and wrong offset are refused
    acc(1'b1, 8'h44, 64'h0, 64'h0);
    acc(1'b1, 8'h45, 64'h8, 64'h0);
    acc(1'b0, 8'h45, 64'h0, 64'h0);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        lf = lfsr_next(lf);
        wd = {wd[47:0], lf};
      end
      acc(1'b1, 8'h45, 64'h0, wd);
      acc(1'b0, 8'h45, 64'h0, 64'h0);
    end
    // Limit on, mask byte 0, phys read/write, virt read, data xlate
    acc(1'b1, 8'h45, 64'h0, 64'h0000_0200_03c0_0008);
    // A cycle idles after raising the limit, like a barrier
    // Two branches in flight, released only by the second resolve
    @(negedge clk_in) br_is = 1'b1;
    repeat (2) @(negedge clk_in);
    br_is = 1'b0;
    br_rs = 1'b1;
    check("hold pending", 1'b1, hold);
    @(negedge clk_in);
    check("hold one left", 1'b1, hold);
    @(negedge clk_in) br_rs = 1'b0;
    check("hold released", 1'b0, hold);
    // 1008 bytes past a transfer, then exactly 1024
    @(negedge clk_in) cti = 1'b1;
    @(negedge clk_in) {cti, fv, fb} = {1'b0, 1'b1, 6'd63};
    repeat (16) @(negedge clk_in);
    check("fetch below", 1'b0, stop);
    fv = 1'b1;
    fb = 6'd16;
    @(negedge clk_in) fv = 1'b0;
    check("fetch at limit", 1'b1, stop);
    dacc(1, 0, 8'h01, watch, watch ^ 64'h8, 1, 0);
    dacc(1, 0, 8'h02, watch, watch, 0, 0);
    dacc(0, 1, 8'h01, watch ^ 64'h8, watch ^ 64'hffff_fe00_0000_0000, 0, 1);
    dacc(0, 1, 8'h01, watch, watch ^ 64'h8, 0, 0);
    dacc(1, 0, 8'h01, watch, watch, 1, 0);
    dacc(1, 0, 8'h01, watch ^ 64'h8, watch ^ 64'h100_0000_0000, 0, 0);
    ifa(64'h1000, 64'h2000);
    // Limit off, virt write only, instruction xlate on
    // Translation change settles before the next access
    acc(1'b1, 8'h45, 64'h0, 64'h0000_0001_fe20_0004);
    check("limit cleared", 4'h0, {bp, hwpf, sq, stop});
    dacc(0, 1, 8'h80, watch, watch, 1, 0);
    ifa(64'h3000, 64'h4000);
    check("answers left", 65'h0, 65'(exp_q.size()));
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
